// ===== adc_link_defs.vh
// constants for the dual-lane serial converter readout
`ifndef ADC_LINK_DEFS_VH
`define ADC_LINK_DEFS_VH
`define ADC_WORD_BITS 16
`define ADC_BIT_COUNT_W 5
`define ADC_CLK_PERIOD_PS 5000
`define ADC_CONV_TIME_NS 100
`define ADC_CONV_CYCLES ((`ADC_CONV_TIME_NS * 1000) / `ADC_CLK_PERIOD_PS)
`define ADC_MIDSCALE 16'h0000
`define ADC_POS_FULL 16'h7FFF
`define ADC_NEG_FULL 16'h8000
`define ADC_FIFO_DEPTH 8
`define ADC_FIFO_ADDR_W 3
`define ADC_SYNC_STAGES 2
`endif

// ===== dual_adc_serial_readout.v
// converter side of a dual-lane clocked serial readout link
`timescale 1ns/1ps
`include "adc_link_defs.vh"
module dual_adc_serial_readout #(
  parameter WORD_BITS = `ADC_WORD_BITS,
  parameter CONV_CYCLES = `ADC_CONV_CYCLES,
  parameter FIFO_DEPTH = `ADC_FIFO_DEPTH,
  parameter FIFO_ADDR_W = `ADC_FIFO_ADDR_W
) (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire convert_strobe_n_in,
  input wire bit_clock_in,
  input wire [WORD_BITS-1:0] odd_sample_in,
  input wire [WORD_BITS-1:0] even_sample_in,
  input wire sample_valid_in,
  output wire sample_ready_out,
  output reg echoed_bit_clock_out,
  output reg first_lane_data_out,
  output reg second_lane_data_out,
  output reg acquiring_out,
  output reg converting_out,
  output reg shifting_out,
  output reg stale_word_out,
  output reg underrun_out,
  output reg ignored_convert_out
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_SHIFT = 3'b100;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  wire [1:0] pins_sync;
  reg cnv_prev_q;
  reg sck_prev_q;
  wire cnv_level;
  wire sck_level;
  wire cnv_fall;
  wire sck_rise;
  wire sck_fall;

  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({convert_strobe_n_in, bit_clock_in}),
    .sync_out(pins_sync)
  );

  assign cnv_level = pins_sync[1];
  assign sck_level = pins_sync[0];
  assign cnv_fall = cnv_prev_q & ~cnv_level;
  assign sck_rise = ~sck_prev_q & sck_level;
  assign sck_fall = sck_prev_q & ~sck_level;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      // synchroniser resets low, so start low too: no false start after reset
      cnv_prev_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      cnv_prev_q <= cnv_level;
      sck_prev_q <= sck_level;
    end
  end

  // ---------------------------------------------------------------
  // sample buffer
  // ---------------------------------------------------------------
  wire [2*WORD_BITS-1:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;

  sample_fifo #(
    .WIDTH(2*WORD_BITS),
    .DEPTH(FIFO_DEPTH),
    .ADDR_W(FIFO_ADDR_W)
  ) u_sample_fifo (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_data_in({odd_sample_in, even_sample_in}),
    .wr_valid_in(sample_valid_in),
    .wr_ready_out(sample_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop)
  );

  // ---------------------------------------------------------------
  // conversion control
  // ---------------------------------------------------------------
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [15:0] conv_cnt_q;
  reg [`ADC_BIT_COUNT_W-1:0] bit_cnt_q;
  reg [WORD_BITS-1:0] held_odd_q;
  reg [WORD_BITS-1:0] held_even_q;
  reg held_valid_q;
  reg [WORD_BITS-1:0] shift_odd_q;
  reg [WORD_BITS-1:0] shift_even_q;
  wire start_ok;
  wire conv_done;
  wire last_bit;

  // conversions are accepted only while idle, not while converting or while the previous word is shifting
  assign start_ok = cnv_fall & (state_q == ST_IDLE);
  assign fifo_pop = start_ok & fifo_valid;
  assign conv_done = (state_q == ST_CONV) && (conv_cnt_q == 16'h0000);
  assign last_bit = (bit_cnt_q == WORD_BITS[`ADC_BIT_COUNT_W-1:0] - 1'b1);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sck_fall & last_bit) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      conv_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (start_ok) begin
        conv_cnt_q <= CONV_CYCLES[15:0] - 16'h0001;
      end else if (state_q == ST_CONV) begin
        conv_cnt_q <= conv_cnt_q - 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // result pipeline: one conversion of latency
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      held_odd_q <= `ADC_MIDSCALE;
      held_even_q <= `ADC_MIDSCALE;
      held_valid_q <= 1'b0;
      shift_odd_q <= `ADC_MIDSCALE;
      shift_even_q <= `ADC_MIDSCALE;
      stale_word_out <= 1'b1;
      underrun_out <= 1'b0;
    end else if (start_ok) begin
      // the new sample is held; the previous one goes out
      shift_odd_q <= held_odd_q;
      shift_even_q <= held_even_q;
      stale_word_out <= ~held_valid_q;
      held_valid_q <= 1'b1;
      underrun_out <= ~fifo_valid;
      if (fifo_valid) begin
        held_odd_q <= fifo_data[2*WORD_BITS-1:WORD_BITS];
        held_even_q <= fifo_data[WORD_BITS-1:0];
      end else begin
        held_odd_q <= `ADC_MIDSCALE;
        held_even_q <= `ADC_MIDSCALE;
      end
    end else if ((state_q == ST_SHIFT) & sck_fall) begin
      shift_odd_q <= {shift_odd_q[WORD_BITS-2:0], 1'b0};
      shift_even_q <= {shift_even_q[WORD_BITS-2:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // bit counter
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bit_cnt_q <= {`ADC_BIT_COUNT_W{1'b0}};
    end else if (state_q != ST_SHIFT) begin
      bit_cnt_q <= {`ADC_BIT_COUNT_W{1'b0}};
    end else if (sck_fall) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // link outputs
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      echoed_bit_clock_out <= 1'b0;
      first_lane_data_out <= 1'b0;
      second_lane_data_out <= 1'b0;
      acquiring_out <= 1'b0;
      converting_out <= 1'b0;
      shifting_out <= 1'b0;
      ignored_convert_out <= 1'b0;
    end else begin
      // lanes load the first bit on entering shift, then change only on echoed falling edges
      echoed_bit_clock_out <= sck_level & (state_q == ST_SHIFT);
      if (state_d == ST_SHIFT) begin
        first_lane_data_out <= (state_q == ST_SHIFT) & sck_fall ?
          shift_odd_q[WORD_BITS-2] : shift_odd_q[WORD_BITS-1];
        second_lane_data_out <= (state_q == ST_SHIFT) & sck_fall ?
          shift_even_q[WORD_BITS-2] : shift_even_q[WORD_BITS-1];
      end else begin
        first_lane_data_out <= 1'b0;
        second_lane_data_out <= 1'b0;
      end
      acquiring_out <= cnv_level & (state_q == ST_IDLE);
      converting_out <= (state_d == ST_CONV);
      shifting_out <= (state_d == ST_SHIFT);
      ignored_convert_out <= cnv_fall & (state_q != ST_IDLE);
    end
  end
endmodule // dual_adc_serial_readout

// ===== host_logic_model.sv
// model of the controlling logic on the far side of the link
`timescale 1ns/1ps
module host_logic_model (
  input wire ref_clk_in,
  input wire echoed_bit_clock_in,
  input wire first_lane_in,
  input wire second_lane_in,
  output reg convert_strobe_n_out,
  output reg bit_clock_out,
  output reg [15:0] odd_word_out,
  output reg [15:0] even_word_out,
  output reg word_valid_out
);
  reg echo_q;
  initial begin
    {convert_strobe_n_out, bit_clock_out, word_valid_out, echo_q} = 4'h8;
    {odd_word_out, even_word_out} = 32'h0000_0000;
  end
  // capture on echo rise, msb first, odd word from first lane
  always @(posedge ref_clk_in) begin
    echo_q <= echoed_bit_clock_in;
    if (echoed_bit_clock_in && !echo_q) begin
      odd_word_out <= {odd_word_out[14:0], first_lane_in};
      even_word_out <= {even_word_out[14:0], second_lane_in};
    end
  end
  task convert(input integer retrig);
    integer i;
    begin
      word_valid_out <= 1'b0;
      convert_strobe_n_out <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
      convert_strobe_n_out <= 1'b1;
      if (retrig != 0) begin
        repeat (2) @(posedge ref_clk_in);
        convert_strobe_n_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        convert_strobe_n_out <= 1'b1;
      end
      repeat (40) @(posedge ref_clk_in);
      #1.3;
      for (i = 0; i < 16; i = i + 1) begin
        #80 bit_clock_out = 1'b1;
        #80 bit_clock_out = 1'b0;
      end
      repeat (4) @(posedge ref_clk_in);
      word_valid_out <= 1'b1;
      @(posedge ref_clk_in);
    end
  endtask
endmodule // host_logic_model

// ===== pin_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // pin_sync

// ===== readout_chk.sv
// port checker for the serial readout block
`timescale 1ns/1ps
module readout_chk #(
  parameter CONV_CYCLES = 20,
  parameter WORD_BITS = 16
) (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire convert_strobe_n_in,
  input wire sample_ready_out,
  input wire echoed_bit_clock_out,
  input wire first_lane_data_out,
  input wire second_lane_data_out,
  input wire acquiring_out,
  input wire converting_out,
  input wire shifting_out,
  input wire stale_word_out,
  input wire ignored_convert_out
);
  reg [7:0] conv_cnt_q;
  reg [5:0] bit_cnt_q;
  reg echo_q;
  always @(posedge ref_clk_in) begin
    echo_q <= echoed_bit_clock_out;
    conv_cnt_q <= (converting_out && !sys_rst_in) ? conv_cnt_q + 8'h01 : 8'h00;
    if (sys_rst_in || converting_out) bit_cnt_q <= 6'h00;
    else if (echoed_bit_clock_out && !echo_q) bit_cnt_q <= bit_cnt_q + 6'h01;
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_rst; $fell(sys_rst_in) |-> stale_word_out && sample_ready_out; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_start; $fell(convert_strobe_n_in) && acquiring_out |-> ##[1:6] converting_out; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_conv; $fell(converting_out) |-> conv_cnt_q == CONV_CYCLES && shifting_out; endproperty
  a_conv: assert property (p_conv) else $error("conversion length wrong");
  property p_bits; $fell(shifting_out) |-> bit_cnt_q == WORD_BITS; endproperty
  a_bits: assert property (p_bits) else $error("bit count wrong");
  property p_acq; converting_out |-> !acquiring_out && !shifting_out; endproperty
  a_acq: assert property (p_acq) else $error("acquiring while busy");
  property p_idle; !shifting_out |-> !first_lane_data_out && !second_lane_data_out; endproperty
  a_idle: assert property (p_idle) else $error("lanes active outside shift");
  property p_hold; echoed_bit_clock_out && $past(echoed_bit_clock_out) |-> $stable({first_lane_data_out, second_lane_data_out}); endproperty
  a_hold: assert property (p_hold) else $error("lane moved while echo high");
  property p_ign; ignored_convert_out |-> !acquiring_out ##1 !ignored_convert_out; endproperty
  a_ign: assert property (p_ign) else $error("bad ignore pulse");
  property p_stale; $fell(stale_word_out) |-> ##[0:1] converting_out; endproperty
  a_stale: assert property (p_stale) else $error("stale flag cleared off start");
endmodule // readout_chk
bind dual_adc_serial_readout readout_chk #(.CONV_CYCLES(CONV_CYCLES), .WORD_BITS(WORD_BITS))
  i_readout_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .convert_strobe_n_in(convert_strobe_n_in), .sample_ready_out(sample_ready_out),
  .echoed_bit_clock_out(echoed_bit_clock_out), .first_lane_data_out(first_lane_data_out),
  .second_lane_data_out(second_lane_data_out), .acquiring_out(acquiring_out),
  .converting_out(converting_out), .shifting_out(shifting_out),
  .stale_word_out(stale_word_out), .ignored_convert_out(ignored_convert_out));

// ===== sample_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter ADDR_W = 3
) (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr_q;
  reg [ADDR_W-1:0] rd_ptr_q;
  reg [ADDR_W:0] count_q;
  wire push;
  wire pop;

  assign wr_ready_out = (count_q != DEPTH[ADDR_W:0]);
  assign rd_valid_out = (count_q != {(ADDR_W+1){1'b0}});
  assign push = wr_valid_in & wr_ready_out;
  assign pop = rd_ready_in & rd_valid_out;
  assign rd_data_out = mem[rd_ptr_q];

  always @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_q] <= wr_data_in;
    end
  end

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_q <= {ADDR_W{1'b0}};
      rd_ptr_q <= {ADDR_W{1'b0}};
      count_q <= {(ADDR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // sample_fifo

// ===== tb.sv
// self-checking bench for the serial readout block
`timescale 1ns/1ps
module tb;
  reg clk, rst, s_valid, ign_seen;
  reg [15:0] odd_s, even_s;
  wire strobe_n, bclk, ready, echo, lane1, lane2, acq, conv, shf, stale, und, ign, wv;
  wire [15:0] ow, ew;
  integer err_count, n_tests, cyc, k;
  dual_adc_serial_readout i_dual_adc_serial_readout (.ref_clk_in(clk), .sys_rst_in(rst),
    .convert_strobe_n_in(strobe_n), .bit_clock_in(bclk), .odd_sample_in(odd_s),
    .even_sample_in(even_s), .sample_valid_in(s_valid), .sample_ready_out(ready),
    .echoed_bit_clock_out(echo), .first_lane_data_out(lane1), .second_lane_data_out(lane2),
    .acquiring_out(acq), .converting_out(conv), .shifting_out(shf), .stale_word_out(stale),
    .underrun_out(und), .ignored_convert_out(ign));
  host_logic_model i_host_logic_model (.ref_clk_in(clk), .echoed_bit_clock_in(echo),
    .first_lane_in(lane1), .second_lane_in(lane2), .convert_strobe_n_out(strobe_n),
    .bit_clock_out(bclk), .odd_word_out(ow), .even_word_out(ew), .word_valid_out(wv));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ign) ign_seen <= 1'b1;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  // ----------
  // helpers
  // ----------
  task check(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task fill(input integer n, input [15:0] ob, input [15:0] eb);
    integer i, acc;
    begin
      acc = 0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        s_valid <= 1'b1;
        odd_s <= ob + i[15:0];
        even_s <= eb + i[15:0];
        @(negedge clk);
        acc = acc + ready;
      end
      @(posedge clk);
      s_valid <= 1'b0;
      check(acc, (n > 8) ? 8 : n, "accepted");
      check(ready, (n > 7) ? 0 : 1, "ready");
    end
  endtask
  task conv_check(input integer rt, input [31:0] pair, input [1:0] flags);
    begin
      @(posedge clk);
      i_host_logic_model.convert(rt);
      check({ow, ew}, pair, "pair");
      check({stale, und}, flags, "flags");
      check(wv, 1, "valid");
      check(acq, 1, "acquire");
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task t_reset;
    begin
      check({stale, ready, shf, conv, lane1}, 5'h18, "reset");
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      check(acq, 1, "idle");
    end
  endtask
  task t_burst;
    begin
      fill(1, 16'h7fff, 16'h8000);
      ign_seen = 1'b0;
      conv_check(0, 32'h0000_0000, 2'h2);
      conv_check(0, 32'h7fff_8000, 2'h1);
      check(ign_seen, 0, "ignore");
      conv_check(1, 32'h0000_0000, 2'h1);
      check(ign_seen, 1, "ignore");
    end
  endtask
  task t_fifo;
    begin
      fill(9, 16'h1231, 16'hfed1);
      for (k = 0; k < 9; k = k + 1)
        conv_check(0, (k == 0) ? 32'h0 : {16'h1230 + k[15:0], 16'hfed0 + k[15:0]}, (k == 8));
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    {err_count, n_tests, cyc} = 0;
    {rst, s_valid, ign_seen} = 3'h4;
    {odd_s, even_s} = 32'h0000_0000;
    repeat (2) @(posedge clk);
    t_reset;
    t_burst;
    t_fifo;
    end_of_test;
  end
endmodule // tb
